/* lsx_pkg.sv */
// Package with opcodes, states, widths and constants of the extended-instruction executor
package lsx_pkg;
    // ==========================================================
    // Widths
    localparam int DATA_W    = 8;
    localparam int DADDR_W   = 9;
    localparam int PADDR_W   = 13;
    localparam int PWORD_W   = 16;
    localparam int BITSEL_W  = 3;
    // ==========================================================
    // Operation codes presented by the main decoder
    typedef enum logic [3:0] {
        LSX_OP_NOP      = 4'h0,
        LSX_OP_SWAP     = 4'h1,   // nibble_exchange_in_place
        LSX_OP_SWAPA    = 4'h2,   // nibble_exchange_to_acc
        LSX_OP_SZ       = 4'h3,   // skip_when_byte_or_bit_zero, byte form
        LSX_OP_SZBIT    = 4'h4,   // skip_when_byte_or_bit_zero, bit form
        LSX_OP_SZA      = 4'h5,   // copy_and_skip_when_zero
        LSX_OP_TRD      = 4'h6,   // table_read_current_page
        LSX_OP_TRDL     = 4'h7,   // table_read_last_page
        LSX_OP_ITRD     = 4'h8,   // incr_then_table_read
        LSX_OP_ITRDL    = 4'h9,   // incr_then_table_read_last_page
        LSX_OP_XORA     = 4'hA,   // xor_into_accumulator
        LSX_OP_XORM     = 4'hB    // xor_into_memory
    } lsx_op_t;
    // ==========================================================
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        LSX_ST_IDLE  = 4'h1,
        LSX_ST_READ  = 4'h2,
        LSX_ST_FLASH = 4'h4,
        LSX_ST_DUMMY = 4'h8
    } lsx_state_t;
    // ==========================================================
    // Reset values
    localparam logic [7:0] ACC_RST  = 8'h00;
    localparam logic [7:0] TPL_RST  = 8'h00;
    localparam logic [7:0] TWH_RST  = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Last page selector: upper program address bits all ones
    localparam logic [4:0] LAST_PAGE = 5'h1F;
endpackage

/* lsx_alu.sv */
// Combinational data path: nibble swap, XOR, zero and bit tests
`timescale 1ns/100ps
module lsx_alu (
    input  wire logic [7:0] acc_i,     // Accumulator value
    input  wire logic [7:0] mem_i,     // Data memory byte
    input  wire logic [2:0] bit_sel_i, // Selected bit number
    output logic      [7:0] swap_o,    // Nibbles exchanged
    output logic      [7:0] xor_o,     // Acc XOR byte
    output logic            mem_zero_o,// Byte equals zero
    output logic            bit_zero_o,// Selected bit is zero
    output logic            xor_zero_o // XOR result is zero
);
    // ==========================================================
    // Pure functions of the operands
    always_comb begin
        swap_o     = {mem_i[3:0], mem_i[7:4]};
        xor_o      = acc_i ^ mem_i;
        mem_zero_o = (mem_i == lsx_pkg::ZERO_BYTE);
        bit_zero_o = ~mem_i[bit_sel_i];
        xor_zero_o = ((acc_i ^ mem_i) == lsx_pkg::ZERO_BYTE);
    end
endmodule

/* lsx_exec.sv */
// Executor for the extended swap, skip, table read and XOR instructions
`timescale 1ns/100ps
// Function
// - Swap in place exchanges byte nibbles, writes back, flags untouched.
// - Swap to accumulator loads swapped nibbles into acc; byte and flags kept.
// - Byte zero test skips next instruction when byte is zero; no write.
// - A taken skip adds one dummy cycle, two cycles in total.
// - Copy and test loads byte into acc, skips when zero.
// - Bit zero test skips when selected bit is zero.
// - Current page table read: low byte to memory, high byte to latch.
// - Last page table read: low byte to memory, high byte to latch.
// - Increment low pointer, then read at high and low pointers.
// - Increment low pointer, then read last page word.
// - XOR to accumulator stores result in acc, updates only zero flag.
// - XOR to memory writes byte, acc unchanged, only zero flag.
module lsx_exec (
    input  wire logic                 mclk_i,        // Core clock, 100 MHz
    input  wire logic                 rst_n_i,       // Async reset, active low
    input  wire logic                 start_i,       // One-cycle instruction start
    input  wire lsx_pkg::lsx_op_t     op_i,          // Operation code
    input  wire logic [8:0]           addr_i,        // Data memory address
    input  wire logic [2:0]           bit_sel_i,     // Bit number for bit test
    input  wire logic [4:0]           pc_page_i,     // Current program page
    input  wire logic [4:0]           tph_i,         // table_pointer_high value
    input  wire logic [7:0]           mem_rdata_i,   // Data memory read data
    input  wire logic [15:0]          flash_rdata_i, // Program word read data
    input  wire logic                 tpl_wr_i,      // Core writes low pointer
    input  wire logic [7:0]           tpl_wdata_i,   // Low pointer write data
    input  wire logic                 acc_wr_i,      // Core writes accumulator
    input  wire logic [7:0]           acc_wdata_i,   // Accumulator write data
    input  wire logic                 z_in_i,        // Zero flag from core
    output logic                      busy_o,        // Instruction in progress
    output logic                      done_o,        // Instruction cycle ended
    output logic                      skip_o,        // Next instruction skipped
    output logic                      mem_rd_o,      // Data memory read strobe
    output logic                      mem_wr_o,      // Data memory write strobe
    output logic [8:0]                mem_addr_o,    // Data memory address
    output logic [7:0]                mem_wdata_o,   // Data memory write data
    output logic                      flash_rd_o,    // Program read strobe
    output logic [12:0]               flash_addr_o,  // Program word address
    output logic [7:0]                acc_o,         // Accumulator
    output logic [7:0]                tpl_o,         // table_pointer_low
    output logic [7:0]                twh_o,         // table_high_byte_latch
    output logic                      z_flag_o,      // Zero flag
    output logic                      z_wr_o         // Zero flag updated pulse
);
    // ==========================================================
    // State
    lsx_pkg::lsx_state_t state_ff, nxt_state;
    lsx_pkg::lsx_op_t    op_ff,    nxt_op;
    logic [2:0]  bit_ff,    nxt_bit;
    logic        busy_ff,   nxt_busy;
    logic        done_ff,   nxt_done;
    logic        skip_ff,   nxt_skip;
    logic        mrd_ff,    nxt_mrd;
    logic        mwr_ff,    nxt_mwr;
    logic [8:0]  maddr_ff,  nxt_maddr;
    logic [7:0]  mwdata_ff, nxt_mwdata;
    logic        frd_ff,    nxt_frd;
    logic [12:0] faddr_ff,  nxt_faddr;
    logic [7:0]  acc_ff,    nxt_acc;
    logic [7:0]  tpl_ff,    nxt_tpl;
    logic [7:0]  twh_ff,    nxt_twh;
    logic        z_ff,      nxt_z;
    logic        zwr_ff,    nxt_zwr;

    logic [7:0] swap_w;
    logic [7:0] xor_w;
    logic       mem_zero_w;
    logic       bit_zero_w;
    logic       xor_zero_w;
    logic [7:0] tpl_inc_w;

    // ==========================================================
    // Data path
    lsx_alu u_alu (
        .acc_i      (acc_ff),
        .mem_i      (mem_rdata_i),
        .bit_sel_i  (bit_ff),
        .swap_o     (swap_w),
        .xor_o      (xor_w),
        .mem_zero_o (mem_zero_w),
        .bit_zero_o (bit_zero_w),
        .xor_zero_o (xor_zero_w)
    );

    assign tpl_inc_w = tpl_ff + 8'h01;

    // ==========================================================
    // Next-state logic; memory read data is valid in READ state
    always_comb begin
        nxt_state  = state_ff;
        nxt_op     = op_ff;
        nxt_bit    = bit_ff;
        nxt_busy   = busy_ff;
        nxt_done   = 1'b0;
        nxt_skip   = 1'b0;
        nxt_mrd    = 1'b0;
        nxt_mwr    = 1'b0;
        nxt_maddr  = maddr_ff;
        nxt_mwdata = mwdata_ff;
        nxt_frd    = 1'b0;
        nxt_faddr  = faddr_ff;
        nxt_acc    = acc_ff;
        nxt_tpl    = tpl_ff;
        nxt_twh    = twh_ff;
        nxt_z      = z_ff;
        nxt_zwr    = 1'b0;
        // Core writes land only while idle; a table read started in the same cycle uses the old pointer, and an increment drops the write
        if (acc_wr_i && state_ff == lsx_pkg::LSX_ST_IDLE) begin
            nxt_acc = acc_wdata_i;
        end
        if (tpl_wr_i && state_ff == lsx_pkg::LSX_ST_IDLE) begin
            nxt_tpl = tpl_wdata_i;
        end
        if (state_ff == lsx_pkg::LSX_ST_IDLE) begin
            nxt_z = z_in_i;
        end
        unique case (state_ff)
            lsx_pkg::LSX_ST_IDLE: begin
                if (start_i && op_i != lsx_pkg::LSX_OP_NOP) begin
                    nxt_op    = op_i;
                    nxt_bit   = bit_sel_i;
                    nxt_maddr = addr_i;
                    nxt_busy  = 1'b1;
                    unique case (op_i)
                        lsx_pkg::LSX_OP_TRD: begin
                            nxt_frd   = 1'b1;
                            nxt_faddr = {pc_page_i, tpl_ff};
                            nxt_state = lsx_pkg::LSX_ST_FLASH;
                        end
                        lsx_pkg::LSX_OP_TRDL: begin
                            nxt_frd   = 1'b1;
                            nxt_faddr = {lsx_pkg::LAST_PAGE, tpl_ff};
                            nxt_state = lsx_pkg::LSX_ST_FLASH;
                        end
                        lsx_pkg::LSX_OP_ITRD: begin
                            nxt_tpl   = tpl_inc_w;
                            nxt_frd   = 1'b1;
                            nxt_faddr = {tph_i, tpl_inc_w};
                            nxt_state = lsx_pkg::LSX_ST_FLASH;
                        end
                        lsx_pkg::LSX_OP_ITRDL: begin
                            nxt_tpl   = tpl_inc_w;
                            nxt_frd   = 1'b1;
                            nxt_faddr = {lsx_pkg::LAST_PAGE, tpl_inc_w};
                            nxt_state = lsx_pkg::LSX_ST_FLASH;
                        end
                        default: begin
                            nxt_mrd   = 1'b1;
                            nxt_state = lsx_pkg::LSX_ST_READ;
                        end
                    endcase
                end
            end
            lsx_pkg::LSX_ST_READ: begin
                nxt_state = lsx_pkg::LSX_ST_IDLE;
                nxt_busy  = 1'b0;
                nxt_done  = 1'b1;
                unique case (op_ff)
                    lsx_pkg::LSX_OP_SWAP: begin
                        nxt_mwr    = 1'b1;
                        nxt_mwdata = swap_w;
                    end
                    lsx_pkg::LSX_OP_SWAPA: begin
                        nxt_acc = swap_w;
                    end
                    lsx_pkg::LSX_OP_SZ: begin
                        nxt_skip = mem_zero_w;
                    end
                    lsx_pkg::LSX_OP_SZA: begin
                        nxt_acc  = mem_rdata_i;
                        nxt_skip = mem_zero_w;
                    end
                    lsx_pkg::LSX_OP_SZBIT: begin
                        nxt_skip = bit_zero_w;
                    end
                    lsx_pkg::LSX_OP_XORA: begin
                        // result to acc, zero flag only
                        nxt_acc = xor_w;
                        nxt_z   = xor_zero_w;
                        nxt_zwr = 1'b1;
                    end
                    lsx_pkg::LSX_OP_XORM: begin
                        nxt_mwr    = 1'b1;
                        nxt_mwdata = xor_w;
                        nxt_z      = xor_zero_w;
                        nxt_zwr    = 1'b1;
                    end
                    default: begin
                        nxt_done = 1'b1;
                    end
                endcase
                // taken skip costs a dummy cycle
                if ((op_ff == lsx_pkg::LSX_OP_SZ && mem_zero_w) ||
                    (op_ff == lsx_pkg::LSX_OP_SZA && mem_zero_w) ||
                    (op_ff == lsx_pkg::LSX_OP_SZBIT && bit_zero_w)) begin
                    // Skip shows only with done, after the dummy cycle
                    nxt_skip  = 1'b0;
                    nxt_state = lsx_pkg::LSX_ST_DUMMY;
                    nxt_busy  = 1'b1;
                    nxt_done  = 1'b0;
                end
            end
            lsx_pkg::LSX_ST_FLASH: begin
                // Table read: low byte to memory, high byte to latch
                nxt_mwr    = 1'b1;
                nxt_mwdata = flash_rdata_i[7:0];
                nxt_twh    = flash_rdata_i[15:8];
                nxt_state  = lsx_pkg::LSX_ST_IDLE;
                nxt_busy   = 1'b0;
                nxt_done   = 1'b1;
            end
            lsx_pkg::LSX_ST_DUMMY: begin
                // Dummy cycle replaces the skipped instruction
                nxt_skip  = 1'b1;
                nxt_state = lsx_pkg::LSX_ST_IDLE;
                nxt_busy  = 1'b0;
                nxt_done  = 1'b1;
            end
            default: begin
                nxt_state = lsx_pkg::LSX_ST_IDLE;
                nxt_busy  = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff  <= lsx_pkg::LSX_ST_IDLE;
            op_ff     <= lsx_pkg::LSX_OP_NOP;
            bit_ff    <= 3'h0;
            busy_ff   <= 1'b0;
            done_ff   <= 1'b0;
            skip_ff   <= 1'b0;
            mrd_ff    <= 1'b0;
            mwr_ff    <= 1'b0;
            maddr_ff  <= 9'h000;
            mwdata_ff <= 8'h00;
            frd_ff    <= 1'b0;
            faddr_ff  <= 13'h0000;
            acc_ff    <= lsx_pkg::ACC_RST;
            tpl_ff    <= lsx_pkg::TPL_RST;
            twh_ff    <= lsx_pkg::TWH_RST;
            z_ff      <= 1'b0;
            zwr_ff    <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            op_ff     <= nxt_op;
            bit_ff    <= nxt_bit;
            busy_ff   <= nxt_busy;
            done_ff   <= nxt_done;
            skip_ff   <= nxt_skip;
            mrd_ff    <= nxt_mrd;
            mwr_ff    <= nxt_mwr;
            maddr_ff  <= nxt_maddr;
            mwdata_ff <= nxt_mwdata;
            frd_ff    <= nxt_frd;
            faddr_ff  <= nxt_faddr;
            acc_ff    <= nxt_acc;
            tpl_ff    <= nxt_tpl;
            twh_ff    <= nxt_twh;
            z_ff      <= nxt_z;
            zwr_ff    <= nxt_zwr;
        end
    end

    assign busy_o       = busy_ff;
    assign done_o       = done_ff;
    assign skip_o       = skip_ff;
    assign mem_rd_o     = mrd_ff;
    assign mem_wr_o     = mwr_ff;
    assign mem_addr_o   = maddr_ff;
    assign mem_wdata_o  = mwdata_ff;
    assign flash_rd_o   = frd_ff;
    assign flash_addr_o = faddr_ff;
    assign acc_o        = acc_ff;
    assign tpl_o        = tpl_ff;
    assign twh_o        = twh_ff;
    assign z_flag_o     = z_ff;
    assign z_wr_o       = zwr_ff;

    // ==========================================================
    // Checks
    AST_SWAP_WB: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == lsx_pkg::LSX_ST_READ && op_ff == lsx_pkg::LSX_OP_SWAP)
        |=> mem_wr_o && mem_wdata_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])})
        else $error("swap write-back wrong");
    AST_SWAPA: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == lsx_pkg::LSX_ST_READ && op_ff == lsx_pkg::LSX_OP_SWAPA)
        |=> !mem_wr_o && acc_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])})
        else $error("swap to acc wrong");
    AST_SZ_SKIP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == lsx_pkg::LSX_ST_READ && op_ff == lsx_pkg::LSX_OP_SZ)
        |=> ##1 (skip_o == $past(mem_rdata_i == 8'h00, 2)) && !mem_wr_o)
        else $error("byte zero skip wrong");
    AST_SKIP_TWO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == lsx_pkg::LSX_ST_DUMMY) |-> busy_o ##1 (skip_o && done_o && !busy_o))
        else $error("skip not two cycles");
    AST_SZA_COPY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == lsx_pkg::LSX_ST_READ && op_ff == lsx_pkg::LSX_OP_SZA)
        |=> acc_o == $past(mem_rdata_i))
        else $error("copy to acc wrong");
    AST_BIT_SKIP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == lsx_pkg::LSX_ST_READ && op_ff == lsx_pkg::LSX_OP_SZBIT
         && mem_rdata_i[bit_ff]) |=> ##1 !skip_o)
        else $error("bit set but skipped");
    AST_TRDL_ADDR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (start_i && state_ff == lsx_pkg::LSX_ST_IDLE && op_i == lsx_pkg::LSX_OP_TRDL)
        |=> flash_rd_o && flash_addr_o[12:8] == 5'h1F ##1 mem_wr_o)
        else $error("last page read wrong");
    AST_TRD_STORE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == lsx_pkg::LSX_ST_FLASH)
        |=> mem_wr_o && mem_wdata_o == $past(flash_rdata_i[7:0])
            && twh_o == $past(flash_rdata_i[15:8]))
        else $error("table read store wrong");
    AST_ITRD_INC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (start_i && state_ff == lsx_pkg::LSX_ST_IDLE && op_i == lsx_pkg::LSX_OP_ITRD)
        |=> tpl_o == $past(tpl_ff) + 8'h01 && flash_addr_o[7:0] == tpl_o
            && flash_addr_o[12:8] == $past(tph_i))
        else $error("increment read wrong");
    AST_ITRDL_INC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (start_i && state_ff == lsx_pkg::LSX_ST_IDLE && op_i == lsx_pkg::LSX_OP_ITRDL)
        |=> tpl_o == $past(tpl_ff) + 8'h01 && flash_addr_o == {5'h1F, tpl_o})
        else $error("increment last page wrong");
    AST_XORA: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == lsx_pkg::LSX_ST_READ && op_ff == lsx_pkg::LSX_OP_XORA)
        |=> acc_o == ($past(acc_ff) ^ $past(mem_rdata_i)) && !mem_wr_o && z_wr_o)
        else $error("xor to acc wrong");
    AST_XORM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_ff == lsx_pkg::LSX_ST_READ && op_ff == lsx_pkg::LSX_OP_XORM)
        |=> mem_wr_o && acc_o == $past(acc_ff)
            && mem_wdata_o == ($past(acc_ff) ^ $past(mem_rdata_i)))
        else $error("xor to memory wrong");
    AST_ZFLAG: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        z_wr_o |-> z_flag_o == (($past(acc_ff) ^ $past(mem_rdata_i)) == 8'h00))
        else $error("zero flag wrong");
endmodule

/* lsx_mem_model.sv */
// Partner model: data memory and program flash seen by the executor
`timescale 1ns/100ps
module lsx_mem_model (
    input  wire logic        mclk_i,       // Core clock
    input  wire logic        mem_wr_i,     // Data write strobe
    input  wire logic [8:0]  mem_addr_i,   // Data address
    input  wire logic [7:0]  mem_wdata_i,  // Data write data
    output logic      [7:0]  mem_rdata_o,  // Data read data
    input  wire logic        flash_rd_i,   // Program read strobe
    input  wire logic [12:0] flash_addr_i, // Program word address
    output logic      [15:0] flash_rdata_o // Program word
);
    logic [7:0]  mem [512];
    logic        frd_ff;
    logic [15:0] fw;
    // ==========================================================
    // Data array answers combinationally on the latched address
    assign mem_rdata_o = mem[mem_addr_i];
    assign fw = {3'h5, flash_addr_i} ^ {flash_addr_i[7:0], 8'h96};
    // Word valid in strobe cycle and the next; else inverted so stale data never matches
    assign flash_rdata_o = (flash_rd_i || frd_ff) ? fw : ~fw;
    // Plain always: the bench preloads the array directly
    always @(posedge mclk_i) begin
        frd_ff <= flash_rd_i;
        if (mem_wr_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
    end
endmodule

/* tb_long_swap_skip_table_xor_exec.sv */
// Self-checking bench of the extended swap, skip, table read and XOR executor
`timescale 1ns/100ps
module tb_long_swap_skip_table_xor_exec;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, tpl_wr_i = 1'b0;
    logic acc_wr_i = 1'b0, z_in_i = 1'b0;
    lsx_pkg::lsx_op_t op_i = lsx_pkg::LSX_OP_NOP;
    logic [8:0]  addr_i = 9'h000;
    logic [2:0]  bit_sel_i = 3'h0;
    logic [4:0]  pc_page_i = 5'h00, tph_i = 5'h00;
    logic [7:0]  tpl_wdata_i = 8'h00, acc_wdata_i = 8'h00, mem_rdata_i;
    logic [15:0] flash_rdata_i;
    logic busy_o, done_o, skip_o, mem_rd_o, mem_wr_o, flash_rd_o, z_flag_o, z_wr_o;
    logic [8:0]  mem_addr_o;
    logic [7:0]  mem_wdata_o, acc_o, tpl_o, twh_o;
    logic [12:0] flash_addr_o;
    int          error_cnt = 0, total_checks = 0, tnum = 0;
    logic [31:0] seed = 32'h5334;
    logic [7:0]  eh = 8'h00;
    // ==========================================================
    // Clock, 100 MHz
    always #5 mclk_i = ~mclk_i;
    lsx_exec i_lsx_exec (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
        .addr_i(addr_i), .bit_sel_i(bit_sel_i), .pc_page_i(pc_page_i), .tph_i(tph_i),
        .mem_rdata_i(mem_rdata_i), .flash_rdata_i(flash_rdata_i), .tpl_wr_i(tpl_wr_i),
        .tpl_wdata_i(tpl_wdata_i), .acc_wr_i(acc_wr_i), .acc_wdata_i(acc_wdata_i),
        .z_in_i(z_in_i), .busy_o(busy_o), .done_o(done_o), .skip_o(skip_o),
        .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o),
        .acc_o(acc_o), .tpl_o(tpl_o), .twh_o(twh_o), .z_flag_o(z_flag_o), .z_wr_o(z_wr_o));
    lsx_mem_model i_mem (.mclk_i(mclk_i), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .flash_rd_i(flash_rd_o),
        .flash_addr_i(flash_addr_o), .flash_rdata_o(flash_rdata_i));
    // ==========================================================
    // Helpers: random source, expected program word, compare
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] pword(input logic [12:0] a);
        return {3'h5, a} ^ {a[7:0], 8'h96};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (e !== s) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // One instruction: mode 0 random byte, 1 zero, 2 equal to acc, 3 all ones and pointer FF
    task automatic run_op(input lsx_pkg::lsx_op_t op, input int mode, input logic hold);
        logic [7:0] a, v, p, ea, em, wl;
        logic [8:0] ad;
        logic [2:0] b;
        logic [4:0] g, h;
        logic [15:0] w;
        logic [12:0] fa;
        logic z, ez, sk, fl;
        int n;
        seed = lfsr(seed); a = seed[7:0]; p = seed[15:8]; ad = seed[24:16];
        seed = lfsr(seed); v = seed[7:0]; b = seed[10:8]; g = seed[15:11]; h = seed[20:16];
        z = seed[31];
        if (mode == 1) v = 8'h00;
        if (mode == 2) v = a;
        if (mode == 3) begin v = 8'hFF; p = 8'hFF; end
        i_mem.mem[ad] = v;
        @(posedge mclk_i);
        acc_wr_i <= 1'b1; acc_wdata_i <= a; tpl_wr_i <= 1'b1; tpl_wdata_i <= p;
        z_in_i <= z; bit_sel_i <= b; pc_page_i <= g; tph_i <= h;
        @(posedge mclk_i);
        acc_wr_i <= 1'b0; tpl_wr_i <= 1'b0; start_i <= 1'b1; op_i <= op; addr_i <= ad;
        @(posedge mclk_i);
        start_i <= hold;
        // Look just after the take edge, while the read strobes stand
        #1;
        ea = a; em = v; ez = z; sk = 1'b0; w = 16'h0000; fa = 13'h0000;
        fl = op inside {[lsx_pkg::LSX_OP_TRD:lsx_pkg::LSX_OP_ITRDL]};
        case (op)
            lsx_pkg::LSX_OP_SWAP:  em = {v[3:0], v[7:4]};
            lsx_pkg::LSX_OP_SWAPA: ea = {v[3:0], v[7:4]};
            lsx_pkg::LSX_OP_SZ:    sk = (v == 8'h00);
            lsx_pkg::LSX_OP_SZBIT: sk = ~v[b];
            lsx_pkg::LSX_OP_SZA:   begin ea = v; sk = (v == 8'h00); end
            lsx_pkg::LSX_OP_TRD:   fa = {g, p};
            lsx_pkg::LSX_OP_TRDL:  fa = {5'h1F, p};
            lsx_pkg::LSX_OP_ITRD:  begin p = p + 8'h01; fa = {h, p}; end
            lsx_pkg::LSX_OP_ITRDL: begin p = p + 8'h01; fa = {5'h1F, p}; end
            lsx_pkg::LSX_OP_XORA:  begin ea = a ^ v; ez = (ea == 8'h00); end
            default:               begin em = a ^ v; ez = (em == 8'h00); end
        endcase
        if (fl) begin
            w = pword(fa);
            em = w[7:0];
            eh = w[15:8];
            chk("faddr", {3'h0, fa}, {3'h0, flash_addr_o});
        end
        chk("busy", 16'h0001, {15'h0, busy_o});
        chk("memrd", {15'h0, ~fl}, {15'h0, mem_rd_o});
        chk("flashrd", {15'h0, fl}, {15'h0, flash_rd_o});
        for (n = 1; n <= 6; n++) begin
            @(posedge mclk_i);
            start_i <= 1'b0;
            #1;
            if (done_o === 1'b1) break;
        end
        if (n > 6) begin error_cnt++; $display("MISMATCH done expected 1 seen 0"); give_verdict(); end
        chk("cycles", sk ? 16'h0002 : 16'h0001, n[15:0]);
        chk("skip", {15'h0, sk}, {15'h0, skip_o});
        chk("acc", {8'h00, ea}, {8'h00, acc_o});
        chk("zflag", {15'h0, ez}, {15'h0, z_flag_o});
        chk("twh", {8'h00, eh}, {8'h00, twh_o});
        chk("tpl", {8'h00, p}, {8'h00, tpl_o});
        @(posedge mclk_i);
        #1;
        chk("mem", {8'h00, em}, {8'h00, i_mem.mem[ad]});
        tnum++;
        $display("test %0d op %0d mode %0d ended", tnum, op, mode);
    endtask
    // ==========================================================
    // Main sequence: every code but NOP in every mode, plus a start held high while busy
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            for (int op = 1; op <= 11; op++) begin
                run_op(lsx_pkg::lsx_op_t'(op), k % 4, 1'b0);
            end
        end
        // Refused start while busy: a second swap would undo the first
        run_op(lsx_pkg::LSX_OP_SWAP, 0, 1'b1);
        give_verdict();
    end
endmodule
